// *** hw/cmpoc_consts.vh ***
// Register offsets, field positions, reset values and selector codes of the comparator output control block.
// Assumes inclusion by the design file; holds definitions only.
`ifndef CMPOC_CONSTS_VH
`define CMPOC_CONSTS_VH

`define CMPOC_ADDR_W 4
`define CMPOC_OFF_CTRL 4'h0
`define CMPOC_OFF_MASK 4'h4
`define CMPOC_OFF_FLAG 4'h8
`define CMPOC_CTRL_RST 32'h00000000
`define CMPOC_MASK_RST 32'h00000000
`define CMPOC_CTRL_WMASK 32'h007fecd3
`define CMPOC_MASK_WMASK 32'h0fffbfff

`define CMPOC_FSEL_HI 22
`define CMPOC_FSEL_LO 20
`define CMPOC_FEN 19
`define CMPOC_FDIV_HI 18
`define CMPOC_FDIV_LO 16
`define CMPOC_ON 15
`define CMPOC_POE 14
`define CMPOC_POL 13
`define CMPOC_AOE 11
`define CMPOC_DUAL 10
`define CMPOC_RES 8
`define CMPOC_EVS_HI 7
`define CMPOC_EVS_LO 6
`define CMPOC_REF 4
`define CMPOC_INV_HI 1
`define CMPOC_INV_LO 0

`define CMPOC_SRCC_HI 27
`define CMPOC_SRCC_LO 24
`define CMPOC_SRCB_HI 23
`define CMPOC_SRCB_LO 20
`define CMPOC_SRCA_HI 19
`define CMPOC_SRCA_LO 16
`define CMPOC_BLANK_LEVEL_SELECT 15
`define CMPOC_OR_GATE_C_ENABLE 13
`define CMPOC_AND_NEG_TO_OR_SELECT 7
`define CMPOC_AND_POS_TO_OR_SELECT 6

`define CMPOC_EV_OFF 2'h0
`define CMPOC_EV_RISE 2'h1
`define CMPOC_EV_FALL 2'h2
`define CMPOC_EV_ANY 2'h3

`define CMPOC_FSRC_SYS 3'h0
`define CMPOC_FSRC_PB 3'h1
`define CMPOC_FSRC_PWM 3'h2
`define CMPOC_FSRC_REF 3'h3

`define CMPOC_BSRC_FAULT_INPUT_TWO 4'he
`define CMPOC_BSRC_FAULT_INPUT_FOUR 4'hf
`define CMPOC_BSRC_PWM_LAST 4'hb

`define CMPOC_FILT_SAMPLES 2'h3
`define CMPOC_DIV_W 7

`endif

// *** hw/cmpoc_channel.v ***
// One comparator/op-amp channel's digital control: registers, blanking, glitch filter, polarity, events.
// Assumes all inputs synchronous to sys_clk_i; clock sources arrive as one-cycle enable ticks.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "cmpoc_consts.vh"

module cmpoc_channel (
   input wire sys_clk_i,
   input wire nrst_i,
   input wire clk_en_i,
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   input wire cmp_raw_i,
   input wire amp_and_gate_i,
   input wire [11:0] pwm_i,
   input wire fault_input_two_i,
   input wire fault_input_four_i,
   input wire peripheral_clock_two_tick_i,
   input wire pwm_special_event_i,
   input wire reference_clock_three_tick_i,
   input wire [3:0] timer_period_tick_i,
   output wire channel_enable_o,
   output wire dual_mode_enable_o,
   output wire reference_select_o,
   output wire [1:0] inverting_input_select_o,
   output wire amp_pin_output_enable_o,
   output reg comparator_output_pin_o,
   output wire comparator_output_pin_oe_o,
   output reg event_o,
   output wire interrupt_flag_o
);

   reg [31:0] ctrl;
   reg [31:0] mask;
   reg flag;
   reg [`CMPOC_DIV_W-1:0] div_cnt;
   reg [1:0] filt_run;
   reg filt_last;
   reg filt_out;
   reg result;
   reg result_d;
   reg next_flag;
   reg src_tick;
   reg div_tick;
   reg and_out;
   reg blank_or;
   reg pre_out;
   reg edge_hit;

   localparam [`CMPOC_DIV_W-1:0] DIV_ONE = 1;

   // Blanking source decode shared by all three mask inputs
   function blank_sel;
      input [3:0] code;
      input [11:0] pwm;
      input f2;
      input f4;
      begin
         if (code <= `CMPOC_BSRC_PWM_LAST) begin
            blank_sel = pwm[code];
         end else if (code == `CMPOC_BSRC_FAULT_INPUT_TWO) begin
            blank_sel = f2;
         end else if (code == `CMPOC_BSRC_FAULT_INPUT_FOUR) begin
            blank_sel = f4;
         end else begin
            blank_sel = 1'b0;
         end
      end
   endfunction

   wire on = ctrl[`CMPOC_ON];
   wire blank_level_select = mask[`CMPOC_BLANK_LEVEL_SELECT];
   wire [2:0] fsel = ctrl[`CMPOC_FSEL_HI:`CMPOC_FSEL_LO];
   wire [2:0] fdiv = ctrl[`CMPOC_FDIV_HI:`CMPOC_FDIV_LO];
   wire [1:0] evs = ctrl[`CMPOC_EVS_HI:`CMPOC_EVS_LO];
   wire blank_a = blank_sel(mask[`CMPOC_SRCA_HI:`CMPOC_SRCA_LO], pwm_i, fault_input_two_i, fault_input_four_i);
   wire blank_b = blank_sel(mask[`CMPOC_SRCB_HI:`CMPOC_SRCB_LO], pwm_i, fault_input_two_i, fault_input_four_i);
   wire blank_c = blank_sel(mask[`CMPOC_SRCC_HI:`CMPOC_SRCC_LO], pwm_i, fault_input_two_i, fault_input_four_i);
   wire [`CMPOC_DIV_W-1:0] div_last = (DIV_ONE << fdiv) - DIV_ONE;

   assign channel_enable_o = on;
   assign dual_mode_enable_o = ctrl[`CMPOC_DUAL];
   assign reference_select_o = ctrl[`CMPOC_REF];
   assign inverting_input_select_o = ctrl[`CMPOC_INV_HI:`CMPOC_INV_LO];
   assign amp_pin_output_enable_o = ctrl[`CMPOC_AOE] & on;
   assign comparator_output_pin_oe_o = ctrl[`CMPOC_POE] & on;
   assign interrupt_flag_o = flag;

   // Filter sample clock source
   always @* begin
      case (fsel)
         `CMPOC_FSRC_SYS: src_tick = 1'b1;
         `CMPOC_FSRC_PB: src_tick = peripheral_clock_two_tick_i;
         `CMPOC_FSRC_PWM: src_tick = pwm_special_event_i;
         `CMPOC_FSRC_REF: src_tick = reference_clock_three_tick_i;
         default: src_tick = timer_period_tick_i[fsel[1:0]];
      endcase
      div_tick = src_tick && (div_cnt == div_last);
   end

   // Blanking gates and output path
   always @* begin
      and_out = blank_a & blank_b & blank_c;
      blank_or = (mask[`CMPOC_OR_GATE_C_ENABLE] & blank_c)
         | (mask[`CMPOC_AND_POS_TO_OR_SELECT] & and_out)
         | (mask[`CMPOC_AND_NEG_TO_OR_SELECT] & ~and_out);
      pre_out = ctrl[`CMPOC_FEN] ? filt_out : cmp_raw_i;
      case (evs)
         `CMPOC_EV_RISE: edge_hit = result & ~result_d;
         `CMPOC_EV_FALL: edge_hit = ~result & result_d;
         `CMPOC_EV_ANY: edge_hit = result ^ result_d;
         default: edge_hit = 1'b0;
      endcase
      next_flag = flag;
      if (wr_i && addr_i == `CMPOC_OFF_FLAG && wdata_i[0]) begin
         next_flag = 1'b0;
      end
      if (on && edge_hit) begin
         next_flag = 1'b1;
      end
   end

   always @(posedge sys_clk_i) begin
      if (!nrst_i) begin
         ctrl <= `CMPOC_CTRL_RST;
         mask <= `CMPOC_MASK_RST;
         flag <= 1'b0;
         div_cnt <= {`CMPOC_DIV_W{1'b0}};
         filt_run <= 2'h0;
         filt_last <= 1'b0;
         filt_out <= 1'b0;
         result <= 1'b0;
         result_d <= 1'b0;
         event_o <= 1'b0;
         comparator_output_pin_o <= 1'b0;
         rdata_o <= 32'h00000000;
      end else if (clk_en_i) begin
         if (wr_i && addr_i == `CMPOC_OFF_CTRL) begin
            ctrl <= wdata_i & `CMPOC_CTRL_WMASK;
         end
         if (wr_i && addr_i == `CMPOC_OFF_MASK) begin
            mask <= wdata_i & `CMPOC_MASK_WMASK;
         end
         flag <= next_flag;
         if (src_tick) begin
            div_cnt <= div_tick ? {`CMPOC_DIV_W{1'b0}} : div_cnt + DIV_ONE;
         end
         if (div_tick) begin
            if (cmp_raw_i != filt_last) begin
               filt_run <= 2'h1;
            end else if (filt_run != `CMPOC_FILT_SAMPLES) begin
               filt_run <= filt_run + 2'h1;
            end
            filt_last <= cmp_raw_i;
            if (cmp_raw_i == filt_last && filt_run == 2'h2) begin
               filt_out <= cmp_raw_i;
            end
         end
         if (!on) begin
            result <= blank_level_select;
         end else if (blank_or) begin
            result <= blank_level_select;
         end else begin
            result <= pre_out ^ ctrl[`CMPOC_POL];
         end
         result_d <= result;
         event_o <= on & edge_hit;
         comparator_output_pin_o <= result;
         rdata_o <= 32'h00000000;
         if (rd_i) begin
            case (addr_i)
               `CMPOC_OFF_CTRL: rdata_o <= ctrl | ({31'h0, result} << `CMPOC_RES);
               `CMPOC_OFF_MASK: rdata_o <= mask;
               `CMPOC_OFF_FLAG: rdata_o <= {31'h0, flag};
               default: rdata_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule // cmpoc_channel

// *** testbench/cmpoc_front.sv ***
// Analog front end model: input selection and a strict compare.
// Assumes levels given as 8-bit codes.
`timescale 1ns/1ps
module cmpoc_front (
   input wire reference_select_i,
   input wire [1:0] inverting_input_select_i,
   input wire [7:0] pos_pin_i,
   input wire [31:0] neg_pins_i,
   output wire cmp_raw_o
);
   wire [7:0] vpos = reference_select_i ? 8'h20 : pos_pin_i;
   wire [7:0] vneg = neg_pins_i[inverting_input_select_i * 8 +: 8];
   assign cmp_raw_o = vpos > vneg;
endmodule // cmpoc_front

// *** testbench/cmpoc_channel_sva.sv ***
// Port checker of one comparator channel.
// Assumes clk_en_i held high.
`timescale 1ns/1ps
module cmpoc_channel_sva (
   input wire sys_clk_i,
   input wire nrst_i,
   input wire [3:0] addr_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire channel_enable_o,
   input wire amp_pin_output_enable_o,
   input wire comparator_output_pin_o,
   input wire comparator_output_pin_oe_o,
   input wire event_o,
   input wire interrupt_flag_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   pin_oe_a: assert property (comparator_output_pin_oe_o |-> channel_enable_o) else $error("pin oe");
   amp_oe_a: assert property (amp_pin_output_enable_o |-> channel_enable_o) else $error("amp oe");
   rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0) else $error("rdata idle");
   rd_result_a: assert property (rd_i && addr_i == 4'h0 |=>
      rdata_o[8] == comparator_output_pin_o) else $error("result bit");
   ev_flag_a: assert property (event_o |-> interrupt_flag_o) else $error("flag");
   ev_edge_a: assert property (event_o |->
      comparator_output_pin_o != $past(comparator_output_pin_o)) else $error("edge");
   flag_hold_a: assert property (interrupt_flag_o && !(wr_i && addr_i == 4'h8) |=> interrupt_flag_o)
      else $error("flag lost");
   on_hold_a: assert property (!wr_i |=> $stable(channel_enable_o)) else $error("enable");
endmodule // cmpoc_channel_sva

// *** testbench/cmpoc_channel_test.sv ***
// Bench of one comparator channel with the front end model.
// Assumes model and checker compiled first.
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; $display("[FAIL] %s %h %h", n, e, a); end end
module cmpoc_channel_test;
   logic sys_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, vhi = 0, peripheral_clock_two_tick_i = 0;
   logic fault_input_two_i = 0, fault_input_four_i = 0, clk_en_i = 1;
   logic [3:0] addr_i = 0;
   logic [11:0] pwm_i = 0;
   logic [31:0] wdata_i = 0, rv, c, m;
   logic [4:0] b;
   int err_total = 0, compares = 0;
   wire [31:0] rdata_o;
   wire [1:0] inverting_input_select_o;
   wire cmp_raw_i, channel_enable_o, dual_mode_enable_o, reference_select_o, amp_pin_output_enable_o;
   wire comparator_output_pin_o, comparator_output_pin_oe_o, event_o, interrupt_flag_o;
   wire [5:0] sel = {comparator_output_pin_oe_o, amp_pin_output_enable_o, dual_mode_enable_o,
      reference_select_o, inverting_input_select_o};
   logic [68:0] rows [11] = '{{32'hff87df2c, 32'h0, 5'b00000}, {32'h0000a000, 32'h0, 5'b00010},
      {32'h0000a000, 32'h0, 5'b00001}, {32'h00008010, 32'h0, 5'b00010}, {32'h00008003, 32'h0, 5'b00010},
      {32'h00008002, 32'h0, 5'b00011}, {32'h00008000, 32'h0b002000, 5'b10010},
      {32'h00008000, 32'h0b002000, 5'b00011}, {32'h00008000, 32'hff5ae000, 5'b01001},
      {32'h00008000, 32'h0e002000, 5'b00110}, {32'h0, 32'h00008000, 5'b00001}};
   always #50 sys_clk_i = ~sys_clk_i;
   cmpoc_front fe_u (.reference_select_i(reference_select_o), .inverting_input_select_i(inverting_input_select_o),
      .pos_pin_i(vhi ? 8'hc0 : 8'h40), .neg_pins_i(32'hff808080), .cmp_raw_o(cmp_raw_i));
   cmpoc_channel dut_u (.*, .amp_and_gate_i(1'b0), .pwm_special_event_i(1'b0),
      .reference_clock_three_tick_i(1'b0), .timer_period_tick_i(4'h0));
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i) begin wr_i <= 1; addr_i <= a; wdata_i <= d; end
      @(posedge sys_clk_i) wr_i <= 0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk_i) begin rd_i <= 1; addr_i <= a; end
      @(posedge sys_clk_i) rd_i <= 0;
      #1 rv = rdata_o;
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge sys_clk_i) peripheral_clock_two_tick_i <= 1;
         @(posedge sys_clk_i) peripheral_clock_two_tick_i <= 0;
      end
   endtask
   task automatic final_report;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk_i);
      nrst_i <= 1;
      foreach (rows[i]) begin
         {c, m, b} = rows[i];
         @(posedge sys_clk_i) {pwm_i[11], fault_input_four_i, fault_input_two_i, vhi} <= b[4:1];
         wr(4'h0, c);
         wr(4'h4, m);
         wt(3);
         `CHK("pin", b[0], comparator_output_pin_o)
         `CHK("sel", {c[15] & c[14], c[15] & c[11], c[10], c[4], c[1:0]}, sel)
         rd(4'h0);
         `CHK("ctrl", c & 32'h007fecd3 | {23'h0, b[0], 8'h0}, rv)
         rd(4'h4);
         `CHK("mask", m & 32'h0fffbfff, rv)
      end
      $display("rows done");
      wr(4'h4, 32'h0);
      for (int e = 0; e < 4; e++) begin
         @(posedge sys_clk_i) vhi <= 0;
         wr(4'h0, 32'h8000 | e << 6);
         wt(3);
         wr(4'h8, 32'h1);
         @(posedge sys_clk_i) vhi <= 1;
         wt(4);
         `CHK("rise", e[0], interrupt_flag_o)
         wr(4'h8, 32'h1);
         @(posedge sys_clk_i) vhi <= 0;
         wt(4);
         `CHK("fall", e[1], interrupt_flag_o)
      end
      $display("events done");
      wr(4'h0, 32'h00088000);
      wt(8);
      @(posedge sys_clk_i) vhi <= 1;
      wt(1);
      @(posedge sys_clk_i) vhi <= 0;
      wt(8);
      `CHK("glitch", 1'b0, comparator_output_pin_o)
      @(posedge sys_clk_i) vhi <= 1;
      wt(8);
      `CHK("steady", 1'b1, comparator_output_pin_o)
      wr(4'h0, 32'h00198000);
      @(posedge sys_clk_i) vhi <= 0;
      wt(10);
      `CHK("notick", 1'b1, comparator_output_pin_o)
      tk(4);
      wt(3);
      `CHK("div", 1'b1, comparator_output_pin_o)
      tk(2);
      wt(3);
      `CHK("div", 1'b0, comparator_output_pin_o)
      $display("filter done");
      @(posedge sys_clk_i) nrst_i <= 0;
      wt(2);
      @(posedge sys_clk_i) nrst_i <= 1;
      rd(4'h0);
      `CHK("reset", 34'h0, {rv, comparator_output_pin_o, interrupt_flag_o})
      $display("reset done");
      @(posedge sys_clk_i) clk_en_i <= 0;
      wr(4'h0, 32'h00008000);
      @(posedge sys_clk_i) clk_en_i <= 1;
      rd(4'h0);
      `CHK("freeze", 32'h0, rv)
      $display("freeze done");
      final_report;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      err_total++;
      final_report;
   end
endmodule // cmpoc_channel_test
bind cmpoc_channel cmpoc_channel_sva chk_u (.*);
